/* File: shared/uwb_rx_cca_pkg.sv */
// Constants, field layouts and state codes for the receive, channel assessment and
// management control block. Assumes a single 100 MHz clock shared with the radio logic.
package uwb_rx_cca_pkg;

	// Clock and header wait.
	localparam int CLK_PERIOD_NS = 10;
	localparam int HDR_TIMEOUT_NS = 20000;
	localparam int HDR_TIMEOUT_CYC = HDR_TIMEOUT_NS / CLK_PERIOD_NS;

	// Attribute values.
	localparam logic [11:0] MAX_PAYLOAD_OCTETS = 12'hfff;
	localparam logic [7:0] OPTIONS_RESET = 8'h00;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

	// Ranging options field positions.
	localparam int OPT_SUPPORTED = 0;
	localparam int OPT_528 = 1;
	localparam int OPT_1056 = 2;
	localparam int OPT_2112 = 3;
	localparam int OPT_4224 = 4;
	localparam int OPT_MID_RANGE = 5;
	localparam int OPT_TOP_RANGE = 6;

	// Header error field positions.
	localparam int HERR_CHANNEL = 2;
	localparam int HERR_RATE = 3;
	localparam int HERR_CHECK = 4;

	// Power state and reset outcome codes.
	typedef enum logic [1:0] {
		PWR_SLEEP = 2'h0,
		PWR_STANDBY = 2'h1,
		PWR_READY = 2'h2
	} power_type;

	typedef enum logic {
		RESET_SUCCESS = 1'h0,
		RESET_FAILED = 1'h1
	} outcome_type;

	// Receive sequencer states.
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_SEARCH = 4'h2,
		RX_HEADER = 4'h4,
		RX_BODY = 4'h8
	} rx_state_type;

endpackage

/* File: rtl/uwb_phy_rx_cca_mgmt.sv */
// Receive start and end handshakes, channel assessment and management attributes.
// Requests, radio events and confirmations are all on clk_i; requests are one-cycle pulses.
`timescale 1ns/1ps

module uwb_phy_rx_cca_mgmt
	import uwb_rx_cca_pkg::*;
#(
	parameter logic [7:0] RANGING_OPTIONS = 8'h71,
	parameter logic [7:0] RANGING_TOLERANCE = 8'h14,
	parameter int HDR_WAIT_CYC = HDR_TIMEOUT_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Receive requests from the access sublayer.
	input wire logic rx_start_req_i,
	input wire logic rx_end_req_i,
	// Receive events from the demodulator.
	input wire logic preamble_sync_i,
	input wire logic header_done_i,
	input wire logic header_check_bad_i,
	input wire logic rate_unsupported_i,
	input wire logic wrong_channel_i,
	input wire logic [11:0] header_length_i,
	input wire logic frame_done_i,
	// Receive answers.
	output logic preamble_search_o,
	output logic rx_start_ind_o,
	output logic rx_start_cnf_o,
	output logic [7:0] header_error_o,
	output logic [11:0] rx_length_o,
	output logic rx_end_ind_o,
	output logic rx_end_cnf_o,
	// Channel assessment.
	input wire logic cca_start_req_i,
	input wire logic cca_end_req_i,
	input wire logic channel_busy_i,
	output logic cca_start_cnf_o,
	output logic cca_end_cnf_o,
	output logic channel_assess_result_o,
	// Management attributes and requests.
	input wire logic power_set_i,
	input wire logic [1:0] power_level_i,
	input wire logic mgmt_reset_req_i,
	input wire logic ranging_start_req_i,
	input wire logic ranging_end_req_i,
	output logic [1:0] phy_power_level_o,
	output logic [11:0] max_payload_octets_o,
	output logic reset_cnf_o,
	output logic phy_reset_outcome_o,
	output logic ranging_start_cnf_o,
	output logic ranging_end_cnf_o,
	output logic [7:0] ranging_capability_options_o,
	output logic [7:0] ranging_clock_tolerance_o,
	output logic [31:0] ranging_timer_value_o
);

	// Reset release through two flip-flops.
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Only the thirteen listed option codes are accepted; any other falls back to none.
	function automatic logic opt_valid(input logic [7:0] o);
		opt_valid = 1'b0;
		case (o)
			8'h00, 8'h03, 8'h05, 8'h09, 8'h11, 8'h23, 8'h25, 8'h29, 8'h31,
			8'h63, 8'h65, 8'h69, 8'h71: opt_valid = 1'b1;
			default: opt_valid = 1'b0;
		endcase
	endfunction

	localparam logic [7:0] OPTIONS_USED = opt_valid(RANGING_OPTIONS) ? RANGING_OPTIONS : 8'h00;

	// Timer mask: low bits by clock option, upper ranges by range bits.
	wire logic [31:0] timer_mask;
	assign timer_mask = {{8{OPTIONS_USED[OPT_TOP_RANGE]}}, {6{OPTIONS_USED[OPT_MID_RANGE]}},
		15'h7fff, OPTIONS_USED[OPT_1056] | OPTIONS_USED[OPT_2112] | OPTIONS_USED[OPT_4224],
		OPTIONS_USED[OPT_2112] | OPTIONS_USED[OPT_4224], OPTIONS_USED[OPT_4224]};

	// Soft reset from the management reset request clears the receive sequencer, the assessment and the ranging timer.
	logic soft_rst_q;
	wire logic clear_all;
	assign clear_all = soft_rst_q;

	// Receive sequencer.
	rx_state_type rx_state_q;
	rx_state_type rx_state_d;
	logic [15:0] wait_q;
	wire logic in_wait;
	wire logic timed_out;
	wire logic take_rx_start;
	wire logic take_rx_end;
	wire logic got_sync;
	wire logic got_header;
	assign in_wait = (rx_state_q == RX_SEARCH) || (rx_state_q == RX_HEADER);
	assign timed_out = in_wait && (wait_q == 16'(HDR_WAIT_CYC - 1));
	assign take_rx_start = rx_start_req_i && (rx_state_q == RX_IDLE);
	assign take_rx_end = rx_end_req_i && (rx_state_q == RX_BODY);
	assign got_sync = preamble_sync_i && (rx_state_q == RX_SEARCH);
	assign got_header = header_done_i && (rx_state_q == RX_HEADER) && !timed_out;

	// Next receive state; a timeout confirms with zero length so the partner ends it.
	always_comb begin
		rx_state_d = rx_state_q;
		unique case (rx_state_q)
			RX_IDLE: if (take_rx_start) rx_state_d = RX_SEARCH;
			RX_SEARCH: begin
				if (timed_out) rx_state_d = RX_BODY;
				else if (got_sync) rx_state_d = RX_HEADER;
			end
			RX_HEADER: if (timed_out || got_header) rx_state_d = RX_BODY;
			RX_BODY: if (take_rx_end) rx_state_d = RX_IDLE;
		endcase
	end

	// Header error code assembled from the three checks.
	wire logic [7:0] herr_code;
	assign herr_code = 8'(({7'h0, header_check_bad_i} << HERR_CHECK)
		| ({7'h0, rate_unsupported_i} << HERR_RATE)
		| ({7'h0, wrong_channel_i} << HERR_CHANNEL));

	// Receive state, timers and answers.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_state_q <= RX_IDLE;
			wait_q <= 16'h0000;
			rx_start_ind_o <= 1'b0;
			rx_start_cnf_o <= 1'b0;
			rx_end_ind_o <= 1'b0;
			rx_end_cnf_o <= 1'b0;
			header_error_o <= 8'h00;
			rx_length_o <= 12'h000;
			preamble_search_o <= 1'b0;
		end else begin
			rx_state_q <= clear_all ? RX_IDLE : rx_state_d;
			wait_q <= in_wait && !clear_all ? wait_q + 16'h0001 : 16'h0000;
			rx_start_ind_o <= got_sync && !timed_out && !clear_all;
			rx_start_cnf_o <= (timed_out || got_header) && !clear_all;
			rx_end_ind_o <= frame_done_i && (rx_state_q == RX_BODY) && !clear_all;
			rx_end_cnf_o <= take_rx_end && !clear_all;
			preamble_search_o <= (rx_state_d == RX_SEARCH) && !clear_all;
			if (got_header) begin
				header_error_o <= herr_code;
				rx_length_o <= header_length_i;
			end else if (timed_out || take_rx_start) begin
				header_error_o <= 8'h00;
				rx_length_o <= 12'h000;
			end
		end
	end

	// Channel assessment: status tracks the medium only while running.
	logic cca_run_q;
	wire logic take_cca_start;
	wire logic take_cca_end;
	assign take_cca_start = cca_start_req_i && !cca_run_q;
	assign take_cca_end = cca_end_req_i && cca_run_q;

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cca_run_q <= 1'b0;
			cca_start_cnf_o <= 1'b0;
			cca_end_cnf_o <= 1'b0;
			channel_assess_result_o <= 1'b0;
		end else begin
			cca_run_q <= clear_all ? 1'b0 : (cca_run_q | take_cca_start) & !take_cca_end;
			cca_start_cnf_o <= take_cca_start && !clear_all;
			cca_end_cnf_o <= take_cca_end && !clear_all;
			if (clear_all) channel_assess_result_o <= 1'b0;
			else if ((take_cca_start || cca_run_q) && !take_cca_end)
				channel_assess_result_o <= channel_busy_i;
		end
	end

	// Ranging timer runs while enabled; start captures a masked copy.
	logic rtimer_en_q;
	logic [31:0] rtimer_q;
	wire logic take_rng_start;
	wire logic take_rng_end;
	assign take_rng_start = ranging_start_req_i && !rtimer_en_q && OPTIONS_USED[OPT_SUPPORTED];
	assign take_rng_end = ranging_end_req_i && rtimer_en_q;

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rtimer_en_q <= 1'b0;
			rtimer_q <= TIMER_RESET;
			ranging_timer_value_o <= TIMER_RESET;
			ranging_start_cnf_o <= 1'b0;
			ranging_end_cnf_o <= 1'b0;
		end else begin
			rtimer_en_q <= clear_all ? 1'b0 : (rtimer_en_q | take_rng_start) & !take_rng_end;
			rtimer_q <= clear_all ? TIMER_RESET : (rtimer_en_q ? rtimer_q + 32'h1 : rtimer_q);
			ranging_start_cnf_o <= take_rng_start && !clear_all;
			ranging_end_cnf_o <= take_rng_end && !clear_all;
			if (clear_all) ranging_timer_value_o <= TIMER_RESET;
			else if (take_rng_start) ranging_timer_value_o <= rtimer_q & timer_mask;
		end
	end

	// Management attributes and reset handshake. The soft reset takes one cycle and
	// cannot fail, so the outcome always reads success.
	wire logic power_ok;
	assign power_ok = power_level_i != 2'h3;

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			soft_rst_q <= 1'b0;
			reset_cnf_o <= 1'b0;
			phy_reset_outcome_o <= RESET_SUCCESS;
			phy_power_level_o <= PWR_SLEEP;
			max_payload_octets_o <= MAX_PAYLOAD_OCTETS;
			ranging_capability_options_o <= OPTIONS_RESET;
			ranging_clock_tolerance_o <= 8'h00;
		end else begin
			soft_rst_q <= mgmt_reset_req_i && !soft_rst_q;
			reset_cnf_o <= soft_rst_q;
			if (soft_rst_q) phy_reset_outcome_o <= RESET_SUCCESS;
			if (soft_rst_q) phy_power_level_o <= PWR_SLEEP;
			else if (power_set_i && power_ok) phy_power_level_o <= power_level_i;
			max_payload_octets_o <= MAX_PAYLOAD_OCTETS;
			ranging_capability_options_o <= OPTIONS_USED;
			ranging_clock_tolerance_o <= RANGING_TOLERANCE;
		end
	end

	// Age of an open receive start, kept apart from wait_q so that the bound is measured
	// from the accepted request and not from the sequencer's own counter.
	logic cnf_open_q;
	logic [15:0] cnf_age_q;

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnf_open_q <= 1'b0;
			cnf_age_q <= 16'h0000;
		end else begin
			cnf_open_q <= (take_rx_start || (cnf_open_q && !rx_start_cnf_o)) && !clear_all;
			cnf_age_q <= cnf_open_q ? cnf_age_q + 16'h0001 : 16'h0000;
		end
	end

	// Checks on the answers.
	a_rx_start_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		(got_header || timed_out) && !clear_all |=> rx_start_cnf_o)
		else $error("receive start confirmation missing after header or timeout");

	a_rx_start_ind: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		rx_start_ind_o |-> $past(rx_state_q) == RX_SEARCH && rx_state_q == RX_HEADER)
		else $error("start indication without preamble synchronization");

	a_rx_wait_bound: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		cnf_open_q |-> cnf_age_q <= 16'(HDR_WAIT_CYC))
		else $error("receive start confirmation later than the header timeout");

	a_rx_end_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		take_rx_end && !clear_all |=> rx_end_cnf_o && rx_state_q == RX_IDLE)
		else $error("end request not stopped and confirmed");

	a_rx_end_ind: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		rx_end_ind_o |-> $past(frame_done_i))
		else $error("end indication without a complete packet");

	a_cca_follow: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		cca_run_q && !cca_end_req_i && !clear_all |=> channel_assess_result_o == $past(channel_busy_i))
		else $error("channel status not following the medium");

	a_cca_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		cca_end_cnf_o ##1 !cca_run_q && !cca_start_req_i && !clear_all |-> $stable(channel_assess_result_o))
		else $error("channel status changed after assessment end");

	a_cca_once: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		cca_start_cnf_o |=> !cca_start_cnf_o)
		else $error("second start confirmation without a new request");

	a_timer_mask: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		(ranging_timer_value_o & ~timer_mask) == 32'h0)
		else $error("inactive ranging timer bits not zero");

	a_reset_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		mgmt_reset_req_i && !soft_rst_q |=> ##1 reset_cnf_o && rx_state_q == RX_IDLE && !cca_run_q)
		else $error("reset not applied and confirmed");

	a_rng_capture: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		take_rng_start && !clear_all |=> ranging_start_cnf_o
			&& ranging_timer_value_o == ($past(rtimer_q) & timer_mask))
		else $error("ranging timer start not captured and confirmed");

	a_payload_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		max_payload_octets_o == 12'hfff)
		else $error("maximum payload attribute wrong");

	a_rx_cnf_source: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		rx_start_cnf_o |-> $past(got_header || timed_out))
		else $error("receive start confirmation without header or timeout");

	a_rx_end_state: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		rx_end_ind_o |-> $past(rx_state_q) == RX_BODY)
		else $error("end indication outside the frame body");

	a_search_level: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		preamble_search_o |-> rx_state_q == RX_SEARCH)
		else $error("preamble search flag outside the search state");

	a_herr_fields: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		(header_error_o & 8'he3) == 8'h00)
		else $error("header error code uses undefined bits");

	a_cca_start_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		take_cca_start && !clear_all |=> cca_start_cnf_o
			&& channel_assess_result_o == $past(channel_busy_i))
		else $error("assessment start not stored and confirmed");

	a_cca_end_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		take_cca_end && !clear_all |=> cca_end_cnf_o && !cca_run_q)
		else $error("assessment end not stopped and confirmed");

	a_power_legal: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		phy_power_level_o != 2'h3)
		else $error("power state holds an undefined code");

	a_options_zero: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		!ranging_capability_options_o[OPT_SUPPORTED] |-> ranging_capability_options_o == 8'h00)
		else $error("ranging options set without support");

	a_rng_end_cnf: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		take_rng_end && !clear_all |=> ranging_end_cnf_o && !rtimer_en_q)
		else $error("ranging timer end not applied and confirmed");

	a_rng_idle: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		!rtimer_en_q && !clear_all |=> $stable(rtimer_q))
		else $error("ranging timer counted while disabled");

	a_reset_outcome: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		reset_cnf_o |-> phy_reset_outcome_o == RESET_SUCCESS)
		else $error("reset confirmation without a success outcome");

endmodule

/* File: bench/mac_side_model.sv */
// Far-side model of the access sublayer: it closes receptions and channel assessments.
// Assumes the block's registered one-cycle answer pulses on the same clock.
`timescale 1ns/1ps

module mac_side_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Answers from the block and a stop command from the bench.
	input wire logic rx_start_cnf_i,
	input wire logic [7:0] header_error_i,
	input wire logic [11:0] rx_length_i,
	input wire logic rx_end_ind_i,
	input wire logic cca_stop_i,
	// Requests to the block.
	output logic rx_end_req_o,
	output logic cca_end_req_o
);
	logic clean;

	// Only a clean header with a length is followed by data, so only then wait for the frame end.
	assign clean = (header_error_i == 8'h00) && (rx_length_i != 12'h000);

	// Requests are registered so that they change just after the clock edge.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_end_req_o <= 1'b0;
			cca_end_req_o <= 1'b0;
		end else begin
			rx_end_req_o <= rx_end_ind_i | (rx_start_cnf_i & ~clean);
			cca_end_req_o <= cca_stop_i;
		end
	end
endmodule

/* File: bench/uwb_phy_rx_cca_mgmt_tb_top.sv */
// Self-checking bench for the receive, assessment and management control block.
// Assumes the far-side model closes receptions; inputs change at the falling edge.
`timescale 1ns/1ps

module uwb_phy_rx_cca_mgmt_tb_top;
	import uwb_rx_cca_pkg::*;
	localparam int HDR = 8;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [9:0] drv = 10'h000;
	logic [2:0] herr_in = 3'h0;
	logic [11:0] len_in = 12'h000;
	logic busy_in = 1'b0;
	logic [1:0] lvl_in = 2'h0;
	logic search, s_ind, s_cnf, e_ind, e_cnf, c_s_cnf, c_e_cnf, result;
	logic r_cnf, outcome, g_s_cnf, g_e_cnf, end_req, c_end_req;
	logic [7:0] herr, opts, tol;
	logic [11:0] rlen, maxp;
	logic [1:0] pwr;
	logic [31:0] tval;
	logic [8:0] ans;
	int bad_count = 0;
	int check_count = 0;

	// Answer pulses gathered so one waiting task serves all of them.
	assign ans = {g_e_cnf, g_s_cnf, r_cnf, c_e_cnf, c_s_cnf, e_cnf, e_ind, s_cnf, s_ind};

	uwb_phy_rx_cca_mgmt #(.RANGING_OPTIONS(8'h23), .RANGING_TOLERANCE(8'h14),
		.HDR_WAIT_CYC(HDR)) dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .rx_start_req_i(drv[0]),
		.rx_end_req_i(end_req), .preamble_sync_i(drv[1]), .header_done_i(drv[2]),
		.header_check_bad_i(herr_in[2]), .rate_unsupported_i(herr_in[1]),
		.wrong_channel_i(herr_in[0]), .header_length_i(len_in), .frame_done_i(drv[3]),
		.preamble_search_o(search), .rx_start_ind_o(s_ind), .rx_start_cnf_o(s_cnf),
		.header_error_o(herr), .rx_length_o(rlen), .rx_end_ind_o(e_ind),
		.rx_end_cnf_o(e_cnf), .cca_start_req_i(drv[4]), .cca_end_req_i(c_end_req),
		.channel_busy_i(busy_in), .cca_start_cnf_o(c_s_cnf), .cca_end_cnf_o(c_e_cnf),
		.channel_assess_result_o(result), .power_set_i(drv[5]), .power_level_i(lvl_in),
		.mgmt_reset_req_i(drv[6]), .ranging_start_req_i(drv[7]),
		.ranging_end_req_i(drv[8]), .phy_power_level_o(pwr), .max_payload_octets_o(maxp),
		.reset_cnf_o(r_cnf), .phy_reset_outcome_o(outcome), .ranging_start_cnf_o(g_s_cnf),
		.ranging_end_cnf_o(g_e_cnf), .ranging_capability_options_o(opts),
		.ranging_clock_tolerance_o(tol), .ranging_timer_value_o(tval));

	mac_side_model model (.clk_i(clk_i), .reset_n_i(reset_n_i), .rx_start_cnf_i(s_cnf),
		.header_error_i(herr), .rx_length_i(rlen), .rx_end_ind_i(e_ind),
		.cca_stop_i(drv[9]), .rx_end_req_o(end_req), .cca_end_req_o(c_end_req));

	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_of_test;
		if (bad_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One-cycle pulse, raised and lowered at falling edges.
	task automatic pulse(input int i);
		@(negedge clk_i);
		drv[i] = 1'b1;
		@(negedge clk_i);
		drv[i] = 1'b0;
	endtask

	// Bounded wait for an answer pulse, looked at in the cycle it stands.
	task automatic wait_ans(input int i, input int lim);
		int n;
		n = 0;
		while (ans[i] !== 1'b1 && n < lim) begin
			@(negedge clk_i);
			n++;
		end
		chk(ans[i], 1'b1);
	endtask

	task automatic t_defaults;
		chk(maxp, 12'hfff);
		chk(pwr, PWR_SLEEP);
		chk(result, 1'b0);
	endtask

	// A whole reception; a clean header goes on to the frame end.
	task automatic t_frame(input logic [2:0] e, input logic [11:0] len);
		herr_in = e;
		len_in = len;
		pulse(0);
		chk(search, 1'b1);
		pulse(1);
		wait_ans(0, 2);
		repeat (3) @(negedge clk_i);
		chk(s_cnf, 1'b0);
		pulse(2);
		wait_ans(1, 2);
		chk(herr, {3'h0, e, 2'h0});
		chk(rlen, len);
		chk(search, 1'b0);
		if (e == 3'h0) begin
			pulse(3);
			wait_ans(2, 2);
		end
		wait_ans(3, 4);
	endtask

	// No header arrives: the confirmation comes from the timeout.
	task automatic t_timeout;
		pulse(0);
		repeat (4) @(negedge clk_i);
		chk(s_cnf, 1'b0);
		wait_ans(1, HDR + 2);
		chk(rlen, 12'h000);
		chk(herr, 8'h00);
		wait_ans(3, 4);
	endtask

	// Start with a busy medium so that the stored result differs from the reset value.
	task automatic t_cca;
		busy_in = 1'b1;
		pulse(4);
		wait_ans(4, 2);
		chk(result, 1'b1);
		busy_in = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(result, 1'b0);
		busy_in = 1'b1;
		repeat (2) @(negedge clk_i);
		chk(result, 1'b1);
		pulse(9);
		wait_ans(5, 4);
		busy_in = 1'b0;
		repeat (3) @(negedge clk_i);
		chk(result, 1'b1);
	endtask

	// Levels 1, 2, 3 and 0; the unused code 3 must leave the state alone.
	task automatic t_power;
		logic [1:0] exp;
		exp = PWR_SLEEP;
		for (int i = 1; i < 5; i++) begin
			lvl_in = i[1:0];
			pulse(5);
			@(negedge clk_i);
			if (lvl_in != 2'h3) exp = lvl_in;
			chk(pwr, exp);
		end
	endtask

	task automatic t_ranging;
		chk(opts, 8'h23);
		chk(tol, 8'h14);
		pulse(7);
		wait_ans(7, 2);
		chk(tval, 32'h0);
		repeat (40) @(negedge clk_i);
		pulse(8);
		wait_ans(8, 2);
		pulse(7);
		wait_ans(7, 2);
		chk(tval & 32'hff00_0007, 32'h0);
		// Enabled for 42 cycles; the 528 MHz option hides bits 2 to 0 of that count.
		chk(tval, 32'h0000_0028);
	endtask

	// Soft reset with assessment busy, power ready and the timer running.
	task automatic t_reset;
		busy_in = 1'b1;
		lvl_in = PWR_READY;
		pulse(5);
		chk(pwr, PWR_READY);
		pulse(4);
		wait_ans(4, 2);
		chk(result, 1'b1);
		@(negedge clk_i);
		pulse(6);
		wait_ans(6, 3);
		chk(outcome, RESET_SUCCESS);
		chk(pwr, PWR_SLEEP);
		chk(result, 1'b0);
		chk(tval, 32'h0);
	endtask

	// Main sequence.
	initial begin
		repeat (4) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		t_defaults;
		t_frame(3'h0, 12'h010);
		for (int i = 0; i < 3; i++) t_frame(3'h1 << i, 12'h020);
		t_timeout;
		t_cca;
		t_power;
		t_ranging;
		t_reset;
		end_of_test;
	end

	// The tests need under a thousand cycles; this limit only catches a hang.
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
endmodule
